//--- hw/stmh_pkg.sv
// Constants and carrier types for the target message handler.
package stmh_pkg;
  localparam logic [7:0] MSG_CMD_DONE    = 8'h00;
  localparam logic [7:0] MSG_EXTENDED    = 8'h01;
  localparam logic [7:0] MSG_SAVE_PTR    = 8'h02;
  localparam logic [7:0] MSG_RESTORE     = 8'h03;
  localparam logic [7:0] MSG_DISCONNECT  = 8'h04;
  localparam logic [7:0] MSG_INIT_ERR    = 8'h05;
  localparam logic [7:0] MSG_ABORT       = 8'h06;
  localparam logic [7:0] MSG_REJECT      = 8'h07;
  localparam logic [7:0] MSG_NOP         = 8'h08;
  localparam logic [7:0] MSG_PARITY_ERR  = 8'h09;
  localparam logic [7:0] MSG_LINKED      = 8'h0a;
  localparam logic [7:0] MSG_LINKED_FLAG = 8'h0b;
  localparam logic [7:0] MSG_DEV_RESET   = 8'h0c;
  localparam logic [7:0] EXT_LEN         = 8'h03;
  localparam logic [7:0] EXT_SDTR        = 8'h01;
  localparam logic [2:0] EXT_PER_IDX     = 3'h3;
  localparam logic [2:0] EXT_OFF_IDX     = 3'h4;
  localparam logic [2:0] EXT_MSG_LEN     = 3'h5;
  localparam logic [7:0] SYNC_MAX_PERIOD = 8'h34;
  localparam logic [7:0] SYNC_MAX_OFFSET = 8'h0f;
  localparam logic [7:0] SYNC_SLOW_LIMIT = 8'hfa;
  localparam int         PERIOD_COUNT    = 20;
  // Supported period codes, fastest first.
  localparam logic [PERIOD_COUNT-1:0][7:0] PERIOD_TABLE = {
    8'hfa, 8'hef, 8'he5, 8'hda, 8'hd0, 8'hc6, 8'hbb, 8'hb1, 8'ha6, 8'h9c,
    8'h91, 8'h87, 8'h7d, 8'h72, 8'h68, 8'h5d, 8'h53, 8'h48, 8'h3e, 8'h34};
  localparam int         ID_MARK_BIT     = 7;
  localparam int         ID_DISCONNECT_PERMITTED_BIT_BIT     = 6;
  localparam logic [2:0] CDB_LAST        = 3'h5;
  localparam logic [1:0] CDB_LAST_TRY    = 2'h2;
  localparam logic [7:0] OP_REWIND       = 8'h01;

  typedef struct packed {
    logic       sync_on;
    logic [7:0] period;
    logic [3:0] offset;
  } stmh_sync_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic       link;
    logic       flag;
    logic       moves_tape;
  } stmh_cmd_t;
endpackage

//--- hw/stmh_cdb_mem.sv
// Six-byte command block store with registered read port.
`timescale 1ns/100ps
module stmh_cdb_mem (
  input  wire logic       clk_i,     // System clock.
  input  wire logic       we_i,      // Write strobe.
  input  wire logic [2:0] waddr_i,   // Write byte index.
  input  wire logic [7:0] wdata_i,   // Write byte.
  input  wire logic [2:0] raddr_i,   // Read byte index.
  output logic      [7:0] rdata_o    // Read byte, one cycle after address.
);
  logic [7:0] mem_r [0:5];

  always_ff @(posedge clk_i) begin
    if (we_i && waddr_i <= 3'h5) begin
      mem_r[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    rdata_o <= (raddr_i <= 3'h5) ? mem_r[raddr_i] : 8'h00;
  end
endmodule

//--- hw/stmh_top.sv
// Target message handler and command block front end.
`timescale 1ns/100ps
module stmh_top (
  input  wire logic               clk_i,                     // System clock, 250 MHz.
  input  wire logic               reset_n_i,                 // Synchronous reset, active low.
  input  wire logic               sync_negotiation_option_i, // Target may start negotiation.
  input  wire logic [2:0]         lun_cfg_i,                 // Configured unit number.
  input  wire logic               beginning_of_tape_i,       // Tape sits at load point.
  input  wire logic               atn_i,                     // Initiator holds attention.
  input  wire logic               msg_out_valid_i,           // Message byte from initiator.
  input  wire logic [7:0]         msg_out_byte_i,            // Message byte value.
  output logic                    msg_in_valid_o,            // Message byte to initiator waits.
  output logic      [7:0]         msg_in_byte_o,             // Message byte to initiator.
  input  wire logic               msg_in_ack_i,              // Bus engine took the byte.
  output logic                    busy_o,                    // Message sender occupied.
  input  wire logic               cdb_valid_i,               // Command block byte strobe.
  input  wire logic [7:0]         cdb_byte_i,                // Command block byte.
  input  wire logic               cdb_perr_i,                // Parity error on this byte.
  input  wire logic [2:0]         cdb_rd_idx_i,              // Command byte read index.
  output logic      [7:0]         cdb_rd_data_o,             // Command byte read data.
  output logic                    cmd_valid_o,               // Legal command ready.
  output stmh_pkg::stmh_cmd_t     cmd_o,                     // Decoded command.
  output logic                    check_cond_o,              // Report check condition.
  output logic                    illegal_request_o,         // Check cause: illegal request.
  output logic                    deferred_report_o,         // Check cause: deferred error.
  output logic                    retry_o,                   // Repeat the last transfer.
  input  wire logic               status_sent_i,             // Status byte went out.
  input  wire logic               disconnect_permitted_bit_request_i,            // Executor wants to disconnect.
  input  wire logic               bus_parity_err_i,          // Data phase parity error.
  input  wire logic               deferred_err_set_i,        // Buffered write failed.
  output logic                    deferred_err_o,            // Deferred error pending.
  input  wire logic               reselect_done_i,           // Reselection completed.
  output logic                    reselect_pending_o,        // Owed a reselection.
  output logic                    bus_free_o,                // Go to bus free.
  output logic                    device_reset_o,            // Device reset received.
  output logic                    disconnect_permitted_bit_o, // Disconnect granted.
  output stmh_pkg::stmh_sync_t    sync_o                     // Agreed transfer mode.
);
  import stmh_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SEND = 3'b010,
    ST_SDPW = 3'b100
  } stmh_state_t;

  function automatic logic op_legal(input logic [7:0] op);
    case (op)
      8'h00, 8'h01, 8'h03, 8'h05, 8'h08, 8'h0a, 8'h0f, 8'h10, 8'h11, 8'h12, 8'h13,
      8'h14, 8'h15, 8'h16, 8'h17, 8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h3b, 8'h3c: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic op_moves(input logic [7:0] op, input logic beginning_of_tape);
    case (op)
      8'h08, 8'h0a, 8'h0f, 8'h10, 8'h11, 8'h13, 8'h19, 8'h1b: return 1'b1;
      OP_REWIND: return !beginning_of_tape;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic is_ident(input logic [7:0] b);
    return b[ID_MARK_BIT] && b[5:3] == 3'h0;
  endfunction

  // Picks the fastest supported period that is equal or slower; a request above SYNC_SLOW_LIMIT gets SYNC_SLOW_LIMIT.
  function automatic logic [7:0] period_round(input logic [7:0] p);
    logic [7:0] r;
    logic       hit;
    r   = SYNC_SLOW_LIMIT;
    hit = 1'b0;
    for (int i = 0; i < PERIOD_COUNT; i++) begin
      if (!hit && PERIOD_TABLE[i] >= p) begin
        r   = PERIOD_TABLE[i];
        hit = 1'b1;
      end
    end
    return r;
  endfunction

  function automatic stmh_sync_t mk_sync(input logic [7:0] p, input logic [7:0] o);
    stmh_sync_t s;
    s.offset  = (o > SYNC_MAX_OFFSET) ? SYNC_MAX_OFFSET[3:0] : o[3:0];
    s.sync_on = (o != 8'h00);
    s.period  = s.sync_on ? period_round(p) : 8'h00;
    return s;
  endfunction

  stmh_state_t     st_r;
  logic [4:0][7:0] buf_r;
  logic [4:0][7:0] last_buf_r;
  logic [2:0]      len_r;
  logic [2:0]      last_len_r;
  logic            free_r;
  logic            sdp_r;
  logic [2:0]      ext_idx_r;
  logic [7:0]      ext_per_r;
  logic            neg_started_r;
  logic            agreed_r;
  logic            no_disconnect_permitted_bit_r;
  logic [2:0]      cdb_cnt_r;
  logic            cdb_bad_r;
  logic            cdb_ill_r;
  logic [1:0]      tries_r;
  stmh_cmd_t       cmd_r;

  logic            can_ld;
  logic            mo;
  logic            ld;
  logic [4:0][7:0] ld_buf;
  logic [2:0]      ld_len;
  logic            ld_free;
  logic            ld_sdp;
  logic            retry_ev;
  logic            abort_ev;
  logic            rst_ev;
  logic            acc_ev;
  stmh_sync_t      acc_sync;
  logic            prop_ev;
  logic            rej_sdp;
  logic            ident_ev;
  logic            cdb_end;
  logic            cdb_bad;
  logic            cdb_ill_nxt;
  logic            tx_done;

  assign can_ld  = (st_r != ST_SEND);
  assign mo      = msg_out_valid_i && can_ld;
  assign cdb_end = cdb_valid_i && cdb_cnt_r == CDB_LAST;
  assign cdb_bad = cdb_bad_r || cdb_perr_i;
  assign tx_done = st_r == ST_SEND && msg_in_ack_i && len_r == 3'h1;
  assign busy_o  = !can_ld;
  assign msg_in_valid_o = (st_r == ST_SEND);
  assign msg_in_byte_o  = buf_r[0];
  assign cmd_o = cmd_r;

  // Chooses at most one outgoing message per cycle; initiator messages come first.
  always_comb begin
    ld       = 1'b0;
    ld_buf   = '0;
    ld_len   = 3'h1;
    ld_free  = 1'b0;
    ld_sdp   = 1'b0;
    retry_ev = 1'b0;
    abort_ev = 1'b0;
    rst_ev   = 1'b0;
    acc_ev   = 1'b0;
    acc_sync = '0;
    prop_ev  = 1'b0;
    rej_sdp  = 1'b0;
    ident_ev = 1'b0;
    if (mo && ext_idx_r == EXT_OFF_IDX) begin
      if (ext_per_r > SYNC_SLOW_LIMIT) begin
        ld        = 1'b1;
        ld_buf[0] = MSG_REJECT;
        acc_ev    = 1'b1;
      end else if (neg_started_r) begin
        acc_ev   = 1'b1;
        acc_sync = mk_sync(ext_per_r, msg_out_byte_i);
      end else if (ext_per_r < SYNC_MAX_PERIOD || msg_out_byte_i > SYNC_MAX_OFFSET) begin
        ld      = 1'b1;
        ld_buf  = {SYNC_MAX_OFFSET, SYNC_MAX_PERIOD, EXT_SDTR, EXT_LEN, MSG_EXTENDED};
        ld_len  = EXT_MSG_LEN;
        prop_ev = 1'b1;
      end else begin
        ld       = 1'b1;
        ld_buf   = {msg_out_byte_i, ext_per_r, EXT_SDTR, EXT_LEN, MSG_EXTENDED};
        ld_len   = EXT_MSG_LEN;
        acc_ev   = 1'b1;
        acc_sync = mk_sync(ext_per_r, msg_out_byte_i);
      end
    end else if (mo && ((ext_idx_r == 3'h1 && msg_out_byte_i != EXT_LEN) ||
                        (ext_idx_r == 3'h2 && msg_out_byte_i != EXT_SDTR))) begin
      ld        = 1'b1;
      ld_buf[0] = MSG_REJECT;
    end else if (mo && ext_idx_r == 3'h0) begin
      if (msg_out_byte_i == MSG_EXTENDED || msg_out_byte_i == MSG_NOP) begin
        ld = 1'b0;
      end else if (msg_out_byte_i == MSG_INIT_ERR) begin
        ld        = 1'b1;
        ld_buf[0] = MSG_RESTORE;
        retry_ev  = 1'b1;
      end else if (msg_out_byte_i == MSG_ABORT) begin
        abort_ev = 1'b1;
      end else if (msg_out_byte_i == MSG_REJECT) begin
        rej_sdp = (last_buf_r[0] == MSG_SAVE_PTR);
        acc_ev  = (last_buf_r[0] == MSG_EXTENDED);
      end else if (msg_out_byte_i == MSG_PARITY_ERR) begin
        ld     = 1'b1;
        ld_buf = last_buf_r;
        ld_len = last_len_r;
      end else if (msg_out_byte_i == MSG_DEV_RESET) begin
        rst_ev = 1'b1;
      end else if (is_ident(msg_out_byte_i) && msg_out_byte_i[2:0] == lun_cfg_i) begin
        ident_ev = 1'b1;
        if (sync_negotiation_option_i && !agreed_r && !neg_started_r) begin
          ld      = 1'b1;
          ld_buf  = {SYNC_MAX_OFFSET, SYNC_MAX_PERIOD, EXT_SDTR, EXT_LEN, MSG_EXTENDED};
          ld_len  = EXT_MSG_LEN;
          prop_ev = 1'b1;
        end
      end else begin
        ld        = 1'b1;
        ld_buf[0] = MSG_REJECT;
      end
    end else if (can_ld && !mo && cdb_end && cdb_bad && tries_r != CDB_LAST_TRY) begin
      ld        = 1'b1;
      ld_buf[0] = MSG_RESTORE;
      retry_ev  = 1'b1;
    end else if (can_ld && !mo && bus_parity_err_i) begin
      ld        = 1'b1;
      ld_buf[0] = MSG_RESTORE;
      retry_ev  = 1'b1;
    end else if (can_ld && !mo && status_sent_i) begin
      ld        = 1'b1;
      ld_buf[0] = !cmd_r.link ? MSG_CMD_DONE : (cmd_r.flag ? MSG_LINKED_FLAG : MSG_LINKED);
      ld_free   = !cmd_r.link;
    end else if (st_r == ST_IDLE && disconnect_permitted_bit_request_i && disconnect_permitted_bit_o &&
                 cmd_r.moves_tape && !no_disconnect_permitted_bit_r) begin
      ld        = 1'b1;
      ld_buf[0] = MSG_SAVE_PTR;
      ld_sdp    = 1'b1;
    end else if (st_r == ST_SDPW && !mo && !atn_i) begin
      ld        = 1'b1;
      ld_buf[0] = MSG_DISCONNECT;
      ld_free   = 1'b1;
    end
  end

  // The sender shifts bytes out of buf_r so the output byte is always a flop.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || rst_ev || abort_ev) begin
      st_r  <= ST_IDLE;
      buf_r <= '0;
      len_r <= 3'h0;
      free_r <= 1'b0;
      sdp_r <= 1'b0;
    end else if (ld) begin
      st_r   <= ST_SEND;
      buf_r  <= ld_buf;
      len_r  <= ld_len;
      free_r <= ld_free;
      sdp_r  <= ld_sdp;
    end else if (st_r == ST_SEND && msg_in_ack_i) begin
      buf_r <= {8'h00, buf_r[4:1]};
      len_r <= len_r - 3'h1;
      if (len_r == 3'h1) begin
        st_r <= sdp_r ? ST_SDPW : ST_IDLE;
      end
    end else if (st_r == ST_SDPW && rej_sdp) begin
      st_r <= ST_IDLE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      last_buf_r <= '0;
      last_len_r <= 3'h1;
    end else if (ld) begin
      last_buf_r <= ld_buf;
      last_len_r <= ld_len;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i || rst_ev) begin
      ext_idx_r <= 3'h0;
      ext_per_r <= 8'h00;
    end else if (mo) begin
      if (ext_idx_r == 3'h0) begin
        ext_idx_r <= (msg_out_byte_i == MSG_EXTENDED) ? 3'h1 : 3'h0;
      end else if (ext_idx_r == EXT_OFF_IDX || ld) begin
        ext_idx_r <= 3'h0;
      end else begin
        ext_idx_r <= ext_idx_r + 3'h1;
      end
      if (ext_idx_r == EXT_PER_IDX) begin
        ext_per_r <= msg_out_byte_i;
      end
    end
  end

  // Negotiated mode; a reject or a too-slow answer leaves asynchronous transfer.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || rst_ev) begin
      sync_o        <= '0;
      agreed_r      <= 1'b0;
      neg_started_r <= 1'b0;
    end else if (acc_ev) begin
      sync_o        <= acc_sync;
      agreed_r      <= acc_sync.sync_on;
      neg_started_r <= 1'b0;
    end else if (prop_ev) begin
      neg_started_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i || rst_ev) begin
      disconnect_permitted_bit_o <= 1'b0;
      no_disconnect_permitted_bit_r                  <= 1'b0;
    end else begin
      if (ident_ev) begin
        disconnect_permitted_bit_o <= msg_out_byte_i[ID_DISCONNECT_PERMITTED_BIT_BIT];
      end
      if (rej_sdp) begin
        no_disconnect_permitted_bit_r <= 1'b1;
      end else if (cdb_end) begin
        no_disconnect_permitted_bit_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i || rst_ev) begin
      reselect_pending_o <= 1'b0;
    end else if (tx_done && buf_r[0] == MSG_DISCONNECT) begin
      reselect_pending_o <= 1'b1;
    end else if (reselect_done_i) begin
      reselect_pending_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      bus_free_o     <= 1'b0;
      device_reset_o <= 1'b0;
      retry_o        <= 1'b0;
    end else begin
      bus_free_o     <= rst_ev || abort_ev || (tx_done && free_r);
      device_reset_o <= rst_ev;
      retry_o        <= retry_ev;
    end
  end

  // Per-byte legality: opcode, unit number, control byte reserved bits, flag without link.
  always_comb begin
    cdb_ill_nxt = cdb_ill_r;
    unique case (cdb_cnt_r)
      3'h0: cdb_ill_nxt = !op_legal(cdb_byte_i);
      3'h1: cdb_ill_nxt = cdb_ill_r || cdb_byte_i[7:5] != lun_cfg_i;
      CDB_LAST: cdb_ill_nxt = cdb_ill_r || cdb_byte_i[7:2] != 6'h00 || (cdb_byte_i[1] && !cdb_byte_i[0]);
      default: cdb_ill_nxt = cdb_ill_r;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i || rst_ev || abort_ev) begin
      cdb_cnt_r <= 3'h0;
      cdb_bad_r <= 1'b0;
      cdb_ill_r <= 1'b0;
    end else if (cdb_valid_i) begin
      cdb_cnt_r <= cdb_end ? 3'h0 : cdb_cnt_r + 3'h1;
      cdb_bad_r <= cdb_end ? 1'b0 : cdb_bad;
      cdb_ill_r <= cdb_end ? 1'b0 : cdb_ill_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i || rst_ev) begin
      tries_r <= 2'h0;
      cmd_r   <= '0;
    end else if (cdb_valid_i) begin
      if (cdb_cnt_r == 3'h0) begin
        cmd_r.opcode     <= cdb_byte_i;
        cmd_r.moves_tape <= op_moves(cdb_byte_i, beginning_of_tape_i);
      end
      if (cdb_end) begin
        cmd_r.link <= cdb_byte_i[0];
        cmd_r.flag <= cdb_byte_i[1];
        tries_r    <= (cdb_bad && tries_r != CDB_LAST_TRY) ? tries_r + 2'h1 : 2'h0;
      end
    end
  end

  // A buffered-write failure survives abort and device reset until reported.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      deferred_err_o <= 1'b0;
    end else if (deferred_err_set_i) begin
      deferred_err_o <= 1'b1;
    end else if (cdb_end && !cdb_bad && !cdb_ill_nxt) begin
      deferred_err_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      cmd_valid_o       <= 1'b0;
      check_cond_o      <= 1'b0;
      illegal_request_o <= 1'b0;
      deferred_report_o <= 1'b0;
    end else begin
      cmd_valid_o       <= cdb_end && !cdb_bad && !cdb_ill_nxt && !deferred_err_o;
      check_cond_o      <= cdb_end && (cdb_bad ? tries_r == CDB_LAST_TRY : (cdb_ill_nxt || deferred_err_o));
      illegal_request_o <= cdb_end && !cdb_bad && cdb_ill_nxt;
      deferred_report_o <= cdb_end && !cdb_bad && !cdb_ill_nxt && deferred_err_o;
    end
  end

  stmh_cdb_mem u_cdb_mem (
    .clk_i   (clk_i),
    .we_i    (cdb_valid_i),
    .waddr_i (cdb_cnt_r),
    .wdata_i (cdb_byte_i),
    .raddr_i (cdb_rd_idx_i),
    .rdata_o (cdb_rd_data_o)
  );

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  a_echo_accept: assert property (mo && ext_idx_r == EXT_OFF_IDX && !neg_started_r &&
    ext_per_r >= SYNC_MAX_PERIOD && ext_per_r <= SYNC_SLOW_LIMIT && msg_out_byte_i <= SYNC_MAX_OFFSET
    |=> msg_in_byte_o == MSG_EXTENDED && buf_r[4] == $past(msg_out_byte_i) && buf_r[3] == $past(ext_per_r))
    else $error("proposal not echoed");
  a_max_reply: assert property (mo && ext_idx_r == EXT_OFF_IDX && !neg_started_r &&
    ext_per_r < SYNC_MAX_PERIOD |=> buf_r[3] == SYNC_MAX_PERIOD && buf_r[4] == SYNC_MAX_OFFSET)
    else $error("maximum not offered");
  a_zero_async: assert property (acc_ev && acc_sync.offset == 4'h0 |=> !sync_o.sync_on)
    else $error("zero offset left synchronous");
  a_abort_free: assert property (mo && ext_idx_r == 3'h0 && msg_out_byte_i == MSG_ABORT
    |=> bus_free_o && st_r == ST_IDLE) else $error("abort without bus free");
  a_reject_unknown: assert property (mo && ext_idx_r == 3'h0 && msg_out_byte_i == 8'h20
    |=> msg_in_valid_o && msg_in_byte_o == MSG_REJECT) else $error("unknown message not rejected");
  a_parity_resend: assert property (mo && ext_idx_r == 3'h0 && msg_out_byte_i == MSG_PARITY_ERR
    |=> msg_in_byte_o == $past(last_buf_r[0]) && len_r == $past(last_len_r)) else $error("no resend");
  a_sdp_reject: assert property (st_r == ST_SDPW && mo && msg_out_byte_i == MSG_REJECT &&
    last_buf_r[0] == MSG_SAVE_PTR |=> st_r == ST_IDLE ##1 !(msg_in_byte_o == MSG_DISCONNECT))
    else $error("disconnect after rejected save pointer");
  a_disconnect_permitted_bit_tape_only: assert property ($rose(msg_in_valid_o) && msg_in_byte_o == MSG_SAVE_PTR
    |-> cmd_r.moves_tape && disconnect_permitted_bit_o) else $error("disconnect for wrong command");
  a_done_free: assert property (tx_done && buf_r[0] == MSG_CMD_DONE |=> bus_free_o)
    else $error("no bus free after command complete");
  a_dev_reset: assert property (mo && ext_idx_r == 3'h0 && msg_out_byte_i == MSG_DEV_RESET
    |=> bus_free_o && device_reset_o && !sync_o.sync_on && !disconnect_permitted_bit_o)
    else $error("device reset incomplete");
  a_cdb_retry: assert property (can_ld && !mo && cdb_end && cdb_bad && tries_r != CDB_LAST_TRY
    |=> msg_in_byte_o == MSG_RESTORE && retry_o && !check_cond_o) else $error("command retry missing");

  c_neg_done: cover property (acc_ev && acc_sync.sync_on);
  c_disconnect: cover property (tx_done && buf_r[0] == MSG_DISCONNECT);
  c_cmd_ok: cover property (cmd_valid_o);
  c_cdb_exhausted: cover property (check_cond_o && !illegal_request_o && !deferred_report_o);
endmodule

//--- tb/stmh_init_model.sv
// Initiator model that takes message-in bytes promptly or with a stall.
`timescale 1ns/100ps
module stmh_init_model (
  input  wire logic        clk_i,   // System clock.
  input  wire logic        slow_i,  // Stall one cycle before each take.
  input  wire logic        valid_i, // Byte waits.
  input  wire logic [7:0]  byte_i,  // Byte value.
  output logic             ack_o,   // Byte taken.
  output logic      [63:0] log_o    // Bytes taken, newest lowest.
);
  logic wait_r = 1'b0;
  initial ack_o = 1'b0;
  initial log_o = '0;
  always @(posedge clk_i) begin
    #1;
    ack_o = valid_i && (!slow_i || wait_r);
    wait_r = valid_i && !wait_r;
    if (ack_o) log_o = {log_o[55:0], byte_i};
  end
endmodule

//--- tb/testbench.sv
// Self-checking bench for the target message handler.
`timescale 1ns/100ps
module testbench;
  import stmh_pkg::*;
  logic        clk_i = 1'b0, reset_n_i = 1'b0, slow = 1'b0, sync_negotiation_option_i = 1'b0;
  logic        beginning_of_tape_i = 1'b0, atn_i = 1'b0, msg_out_valid_i = 1'b0, cdb_valid_i = 1'b0;
  logic        cdb_perr_i = 1'b0, status_sent_i = 1'b0, disconnect_permitted_bit_request_i = 1'b0, bus_parity_err_i = 1'b0;
  logic        deferred_err_set_i = 1'b0, reselect_done_i = 1'b0;
  logic [2:0]  lun_cfg_i = 3'h0, cdb_rd_idx_i = 3'h0, pulses;
  logic [7:0]  msg_out_byte_i = 8'h00, cdb_byte_i = 8'h00, msg_in_byte_o, cdb_rd_data_o;
  logic        msg_in_valid_o, msg_in_ack_i, busy_o, cmd_valid_o, check_cond_o, illegal_request_o;
  logic        deferred_report_o, retry_o, deferred_err_o, reselect_pending_o, bus_free_o;
  logic        device_reset_o, disconnect_permitted_bit_o;
  stmh_cmd_t   cmd_o;
  stmh_sync_t  sync_o;
  logic [63:0] log_o, log;
  int          fails = 0, n_checks = 0;
  // Row: message byte, reply byte (00 for none), pulse check enable, {retry, bus free, device reset}.
  // Device reset also goes to bus free, so its row expects both pulses.
  logic [19:0] rows [6] = '{20'h55078, 20'h0503c, 20'h09030, 20'h08008, 20'h0600a, 20'h0c00b};
  stmh_top dut_u (.*);
  stmh_init_model model_u (.clk_i, .slow_i(slow), .valid_i(msg_in_valid_o), .byte_i(msg_in_byte_o),
    .ack_o(msg_in_ack_i), .log_o(log_o));
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) pulses <= pulses | {retry_o, bus_free_o, device_reset_o};
  task chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task send(input logic [7:0] b);
    @(posedge clk_i) #1 msg_out_valid_i = 1'b1;
    msg_out_byte_i = b;
    @(posedge clk_i) #1 msg_out_valid_i = 1'b0;
  endtask
  task ext(input logic [39:0] m);
    for (int k = 4; k >= 0; k--) send(m[8*k +: 8]);
    repeat (30) @(posedge clk_i);
  endtask
  task test_done;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #20000;
    fails++;
    test_done;
  end
  initial begin
    repeat (8) @(posedge clk_i);
    #1 reset_n_i = 1'b1;
    chk({sync_o, deferred_err_o}, 0);
    foreach (rows[i]) begin
      log = log_o;
      pulses = 3'h0;
      send(rows[i][19:12]);
      repeat (12) @(posedge clk_i);
      chk(log_o[7:0], rows[i][11:4] ? rows[i][11:4] : log[7:0]);
      if (rows[i][3]) chk(pulses, rows[i][2:0]);
    end
    ext(40'h0103013e07);
    chk(log_o[39:0], 40'h0103013e07);
    chk(sync_o, {1'b1, 8'h3e, 4'h7});
    send(8'hc0);
    repeat (2) @(posedge clk_i);
    chk(disconnect_permitted_bit_o, 1'b1);
    slow = 1'b1;
    ext(40'h010301201f);
    chk(log_o[39:0], {MSG_EXTENDED, EXT_LEN, EXT_SDTR, SYNC_MAX_PERIOD, SYNC_MAX_OFFSET});
    @(posedge clk_i) #1 deferred_err_set_i = 1'b1;
    @(posedge clk_i) #1 deferred_err_set_i = 1'b0;
    send(MSG_ABORT);
    repeat (4) @(posedge clk_i);
    chk(deferred_err_o, 1'b1);
    test_done;
  end
endmodule
